// file: dxr_pkg.sv
// Shared constants and carrier types for the debug exit and resynchronisation block
package dxr_pkg;

    // Instruction scan chain layout, shifted most significant bit first
    localparam int SCAN_LEN   = 33;
    localparam int FLAG_BIT   = 32;
    localparam int INSTR_W    = 32;

    // No-operation word that marks the final word of an exit sequence
    localparam logic [INSTR_W-1:0] NOP_WORD = 32'he1a00000;

    // Program counter bookkeeping, in instruction addresses
    localparam int PC_OFFSET_W = 16;
    localparam int ENTRY_ADV   = 4;
    localparam int DEBUG_ADV   = 1;
    localparam int SYS_ADV     = 5;

    // Address to byte scaling: 4 addresses give 16 bytes full width, 8 compressed
    localparam int SHIFT_FULL       = 2;
    localparam int SHIFT_COMPRESSED = 1;

    // Fetches still masked by the acknowledge after leaving debug state
    localparam int EXIT_FETCHES = 3;
    localparam int FETCH_CNT_W  = 2;

    // Core-side events, all arriving asynchronously on pins
    typedef struct packed {
        logic breakpointHit;
        logic watchpointHit;
        logic debugRequest;
        logic dataAbort;
        logic exceptionPending;
        logic abortVectorFetch;
        logic instrFetch;
        logic accessDone;
        logic accessAbort;
        logic compressedState;
    } dxr_core_in_type;

    // Status reported back to the core and the debugger
    typedef struct packed {
        logic [PC_OFFSET_W-1:0] pcOffset;
        logic [PC_OFFSET_W+1:0] pcOffsetBytes;
        logic                   abortMode;
        logic                   exceptionMode;
        logic                   compressedAtEntry;
    } dxr_status_type;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_ENTRY_WAIT,
        ST_ENTER,
        ST_HALTED,
        ST_SYS_ACCESS,
        ST_RESYNC,
        ST_EXIT_MASK
    } dxr_state_type;

endpackage : dxr_pkg

// file: dxr_debug_exit_resync.sv
// Debug state entry, exit and clock resynchronisation between system and scan clocks
`timescale 1ns/1ps

module dxr_debug_exit_resync (
    // System clock domain
    input  wire logic                     clock,
    input  wire logic                     rst,
    // Core events from pins
    input  wire dxr_pkg::dxr_core_in_type coreIn,
    // Core control and status
    output logic                          debugAcknowledge,
    output logic                          debugClockSelect,
    output logic                          fetchEnable,
    output logic                          pipelineFlush,
    output dxr_pkg::dxr_status_type       dbgStatus,
    // Scan link, on the scan clock
    input  wire logic                     debugScanClock,
    input  wire logic                     scanShift,
    input  wire logic                     scanDataIn,
    input  wire logic                     scanUpdate,
    input  wire logic                     resumeSelected,
    input  wire logic                     tapRunTestIdle,
    // Scan link results
    output logic                          chainSystemMode,
    output logic                          systemSpeedFlag,
    output logic [dxr_pkg::INSTR_W-1:0]   loadedInstr
);

    localparam int OW = dxr_pkg::PC_OFFSET_W;

    function automatic logic ackState(input dxr_pkg::dxr_state_type s);
        ackState = (s == dxr_pkg::ST_ENTER) || (s == dxr_pkg::ST_HALTED) ||
                   (s == dxr_pkg::ST_SYS_ACCESS) || (s == dxr_pkg::ST_EXIT_MASK);
    endfunction : ackState

    // System domain declarations
    dxr_pkg::dxr_core_in_type coreSync1_q;
    dxr_pkg::dxr_core_in_type coreIn_q;
    dxr_pkg::dxr_state_type   state_q;
    dxr_pkg::dxr_state_type   state_d;
    logic [2:0]               dbgTglSys_q;
    logic [2:0]               resTglSys_q;
    logic                     dbgEvt;
    logic                     resumeEvt;
    logic [OW-1:0]            pcOffset_q;
    logic [OW-1:0]            pcOffset_d;
    logic                     abortMode_q;
    logic                     exceptionMode_q;
    logic                     compressed_q;
    logic [dxr_pkg::FETCH_CNT_W-1:0] fetchCnt_q;
    logic                     ack_q;
    logic                     clkSel_q;
    logic                     fetchEn_q;
    logic                     flush_q;
    logic                     haltTgl_q;
    logic                     lastExitFetch;

    // Link domain declarations
    logic                          rstMeta_q;
    logic                          rstLink_q;
    logic                          haltSync1_q;
    logic                          haltLink_q;
    logic [2:0]                    haltTglLink_q;
    logic [dxr_pkg::SCAN_LEN-1:0]  shift_q;
    logic                          loadedFlag_q;
    logic [dxr_pkg::INSTR_W-1:0]   loadedInstr_q;
    logic                          dbgTgl_q;
    logic                          resTgl_q;
    logic                          resNop_q;
    logic                          rtiPrev_q;
    logic                          sysMode_q;
    logic                          idleEntry;

    // Pins pass two flops before use
    always_ff @(posedge clock) begin
        coreSync1_q <= coreIn;
        coreIn_q    <= coreSync1_q;
    end

    // Toggle events from the scan domain; data beside them is held stable
    always_ff @(posedge clock) begin
        if (rst) begin
            dbgTglSys_q <= 3'h0;
            resTglSys_q <= 3'h0;
        end else begin
            dbgTglSys_q <= {dbgTglSys_q[1:0], dbgTgl_q};
            resTglSys_q <= {resTglSys_q[1:0], resTgl_q};
        end
    end

    assign dbgEvt    = dbgTglSys_q[2] ^ dbgTglSys_q[1];
    assign resumeEvt = resTglSys_q[2] ^ resTglSys_q[1];
    assign lastExitFetch = coreIn_q.instrFetch &&
        (fetchCnt_q == dxr_pkg::FETCH_CNT_W'(dxr_pkg::EXIT_FETCHES - 1));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dxr_pkg::ST_RUN: begin
                if (coreIn_q.watchpointHit && coreIn_q.dataAbort) begin
                    state_d = dxr_pkg::ST_ENTRY_WAIT;
                end else if (coreIn_q.breakpointHit || coreIn_q.watchpointHit || coreIn_q.debugRequest) begin
                    state_d = dxr_pkg::ST_ENTER;
                end
            end
            dxr_pkg::ST_ENTRY_WAIT: begin
                if (coreIn_q.abortVectorFetch) begin
                    state_d = dxr_pkg::ST_ENTER;
                end
            end
            dxr_pkg::ST_ENTER: begin
                state_d = dxr_pkg::ST_HALTED;
            end
            dxr_pkg::ST_HALTED: begin
                // A resume only arrives when the loaded word carried the flag
                if (resumeEvt) begin
                    state_d = resNop_q ? dxr_pkg::ST_EXIT_MASK : dxr_pkg::ST_SYS_ACCESS;
                end
            end
            dxr_pkg::ST_SYS_ACCESS: begin
                if (coreIn_q.accessDone) begin
                    state_d = dxr_pkg::ST_RESYNC;
                end
            end
            dxr_pkg::ST_RESYNC: begin
                state_d = dxr_pkg::ST_HALTED;
            end
            dxr_pkg::ST_EXIT_MASK: begin
                if (lastExitFetch) begin
                    state_d = dxr_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= dxr_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Acknowledge leads the clock switch by one cycle on entry; after a resync both rise in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q     <= 1'b0;
            clkSel_q  <= 1'b0;
            fetchEn_q <= 1'b1;
            flush_q   <= 1'b0;
        end else begin
            ack_q     <= ackState(state_d);
            clkSel_q  <= (state_d == dxr_pkg::ST_HALTED);
            fetchEn_q <= (state_d == dxr_pkg::ST_RUN) || (state_d == dxr_pkg::ST_ENTRY_WAIT) ||
                         (state_d == dxr_pkg::ST_EXIT_MASK);
            flush_q   <= (state_d == dxr_pkg::ST_ENTER) && (state_q != dxr_pkg::ST_ENTER);
        end
    end

    // Exit fetch counter, cleared on every resume
    always_ff @(posedge clock) begin
        if (rst) begin
            fetchCnt_q <= '0;
        end else if (state_q != dxr_pkg::ST_EXIT_MASK) begin
            fetchCnt_q <= '0;
        end else if (coreIn_q.instrFetch) begin
            fetchCnt_q <= fetchCnt_q + dxr_pkg::FETCH_CNT_W'(1);
        end
    end

    // Program counter offset in addresses
    always_comb begin
        pcOffset_d = pcOffset_q;
        if (state_d == dxr_pkg::ST_ENTER && state_q != dxr_pkg::ST_ENTER) begin
            pcOffset_d = OW'(dxr_pkg::ENTRY_ADV);
        end else if (state_q == dxr_pkg::ST_HALTED && dbgEvt) begin
            pcOffset_d = pcOffset_q + OW'(dxr_pkg::DEBUG_ADV);
        end else if (state_q == dxr_pkg::ST_SYS_ACCESS && coreIn_q.accessDone) begin
            pcOffset_d = pcOffset_q + OW'(dxr_pkg::SYS_ADV);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pcOffset_q <= '0;
        end else begin
            pcOffset_q <= pcOffset_d;
        end
    end

    // Entry mode flags, kept until the program runs again; an aborted system access also sets abortMode
    always_ff @(posedge clock) begin
        if (rst) begin
            abortMode_q     <= 1'b0;
            exceptionMode_q <= 1'b0;
            compressed_q    <= 1'b0;
        end else if (state_q == dxr_pkg::ST_RUN) begin
            abortMode_q     <= coreIn_q.watchpointHit && coreIn_q.dataAbort;
            exceptionMode_q <= coreIn_q.watchpointHit && coreIn_q.exceptionPending;
            compressed_q    <= coreIn_q.compressedState;
        end else if (state_q == dxr_pkg::ST_SYS_ACCESS && coreIn_q.accessAbort) begin
            abortMode_q     <= 1'b1;
        end
    end

    // Every return to debug state tells the scan side to leave system mode
    always_ff @(posedge clock) begin
        if (rst) begin
            haltTgl_q <= 1'b0;
        end else if (state_d == dxr_pkg::ST_HALTED && state_q != dxr_pkg::ST_HALTED) begin
            haltTgl_q <= ~haltTgl_q;
        end
    end

    assign debugAcknowledge           = ack_q;
    assign debugClockSelect           = clkSel_q;
    assign fetchEnable                = fetchEn_q;
    assign pipelineFlush              = flush_q;
    assign dbgStatus.pcOffset         = pcOffset_q;
    assign dbgStatus.pcOffsetBytes    = (OW+2)'(pcOffset_q) << (compressed_q ? dxr_pkg::SHIFT_COMPRESSED
                                                                           : dxr_pkg::SHIFT_FULL);
    assign dbgStatus.abortMode        = abortMode_q;
    assign dbgStatus.exceptionMode    = exceptionMode_q;
    assign dbgStatus.compressedAtEntry = compressed_q;

    // Link domain: reset and halted level brought over by two flops
    always_ff @(posedge debugScanClock) begin
        rstMeta_q   <= rst;
        rstLink_q   <= rstMeta_q;
        haltSync1_q <= clkSel_q;
        haltLink_q  <= haltSync1_q;
    end

    always_ff @(posedge debugScanClock) begin
        if (rstLink_q) begin
            haltTglLink_q <= 3'h0;
        end else begin
            haltTglLink_q <= {haltTglLink_q[1:0], haltTgl_q};
        end
    end

    // Flag bit enters first and ends at the top of the chain
    always_ff @(posedge debugScanClock) begin
        if (rstLink_q) begin
            shift_q <= '0;
        end else if (scanShift) begin
            shift_q <= {shift_q[dxr_pkg::SCAN_LEN-2:0], scanDataIn};
        end
    end

    // Core clocked once for a flag-clear word while halted: word enters the pipeline
    always_ff @(posedge debugScanClock) begin
        if (rstLink_q) begin
            loadedFlag_q  <= 1'b0;
            loadedInstr_q <= '0;
            dbgTgl_q      <= 1'b0;
        end else if (scanUpdate) begin
            loadedFlag_q  <= shift_q[dxr_pkg::FLAG_BIT];
            loadedInstr_q <= shift_q[dxr_pkg::INSTR_W-1:0];
            if (!shift_q[dxr_pkg::FLAG_BIT] && haltLink_q) begin
                dbgTgl_q <= ~dbgTgl_q;
            end
        end
    end

    assign idleEntry = tapRunTestIdle && !rtiPrev_q;

    // Restart only on entering idle, so several cores restart together
    always_ff @(posedge debugScanClock) begin
        if (rstLink_q) begin
            rtiPrev_q <= 1'b0;
            resTgl_q  <= 1'b0;
            resNop_q  <= 1'b0;
            sysMode_q <= 1'b0;
        end else begin
            rtiPrev_q <= tapRunTestIdle;
            if (idleEntry && resumeSelected && loadedFlag_q && haltLink_q && !sysMode_q) begin
                resTgl_q  <= ~resTgl_q;
                resNop_q  <= (loadedInstr_q == dxr_pkg::NOP_WORD);
                sysMode_q <= 1'b1;
            end else if (haltTglLink_q[2] ^ haltTglLink_q[1]) begin
                sysMode_q <= 1'b0;
            end
        end
    end

    assign chainSystemMode = sysMode_q;
    assign systemSpeedFlag = loadedFlag_q;
    assign loadedInstr     = loadedInstr_q;

    // Checks, system domain
    sequence exitLastFetch;
        state_q == dxr_pkg::ST_EXIT_MASK && lastExitFetch;
    endsequence
    sequence ackDipThenRise;
        !debugAcknowledge ##1 debugAcknowledge;
    endsequence
    a_ack_in_halt: assert property (@(posedge clock) disable iff (rst)
        state_q == dxr_pkg::ST_HALTED |-> debugAcknowledge && !fetchEnable)
        else $error("acknowledge low or fetch enabled while halted");
    a_flush_on_entry: assert property (@(posedge clock) disable iff (rst)
        state_q == dxr_pkg::ST_ENTER && $past(state_q) != dxr_pkg::ST_ENTER |-> pipelineFlush)
        else $error("pipeline not flushed on entry");
    a_exit_three_fetches: assert property (@(posedge clock) disable iff (rst)
        exitLastFetch |=> !debugAcknowledge && fetchEnable)
        else $error("acknowledge not released after third fetch");
    a_exit_ack_held: assert property (@(posedge clock) disable iff (rst)
        state_q == dxr_pkg::ST_EXIT_MASK && !lastExitFetch |=> debugAcknowledge)
        else $error("acknowledge fell before third fetch");
    a_sys_ack_dip: assert property (@(posedge clock) disable iff (rst)
        state_q == dxr_pkg::ST_SYS_ACCESS && coreIn_q.accessDone |=> ackDipThenRise)
        else $error("acknowledge did not dip and rise after system access");
    a_entry_pc_offset: assert property (@(posedge clock) disable iff (rst)
        state_q == dxr_pkg::ST_ENTER |-> pcOffset_q == OW'(dxr_pkg::ENTRY_ADV) &&
            dbgStatus.pcOffsetBytes == (compressed_q ? 18'h00008 : 18'h00010))
        else $error("entry offset wrong");
    a_debug_instr_offset: assert property (@(posedge clock) disable iff (rst)
        state_q == dxr_pkg::ST_HALTED && dbgEvt && state_d == dxr_pkg::ST_HALTED
            |=> pcOffset_q == $past(pcOffset_q) + OW'(dxr_pkg::DEBUG_ADV))
        else $error("debug instruction offset wrong");
    a_sys_pc_offset: assert property (@(posedge clock) disable iff (rst)
        state_q == dxr_pkg::ST_SYS_ACCESS && coreIn_q.accessDone
            |=> pcOffset_q == $past(pcOffset_q) + OW'(dxr_pkg::SYS_ADV))
        else $error("system access offset wrong");
    a_watch_abort_hold: assert property (@(posedge clock) disable iff (rst)
        state_q == dxr_pkg::ST_ENTRY_WAIT && !coreIn_q.abortVectorFetch |=> !debugAcknowledge)
        else $error("debug entered before abort vector fetch");
    a_sys_abort_mode: assert property (@(posedge clock) disable iff (rst)
        state_q == dxr_pkg::ST_SYS_ACCESS && coreIn_q.accessAbort |=> dbgStatus.abortMode)
        else $error("aborted system access left abort mode clear");
    a_clock_switch: assert property (@(posedge clock) disable iff (rst)
        $rose(debugAcknowledge) && state_q == dxr_pkg::ST_ENTER |-> !debugClockSelect ##1 debugClockSelect)
        else $error("clock switch not one cycle after acknowledge");
    // Checks, link domain
    a_resume_on_idle: assert property (@(posedge debugScanClock) disable iff (rstLink_q)
        !idleEntry |=> $stable(resTgl_q))
        else $error("resume issued outside idle entry");
    a_flag_capture: assert property (@(posedge debugScanClock) disable iff (rstLink_q)
        scanUpdate |=> systemSpeedFlag == $past(shift_q[dxr_pkg::FLAG_BIT]))
        else $error("flag bit not taken from chain top");
    a_shift_order: assert property (@(posedge debugScanClock) disable iff (rstLink_q)
        scanShift ##1 scanShift |=> shift_q[1] == $past(scanDataIn, 2))
        else $error("scan order wrong");

endmodule : dxr_debug_exit_resync

// file: dxr_debugger_model.sv
// Debugger model driving the scan chain and TAP state lines
`timescale 1ns/1ps
module dxr_debugger_model (
    // Scan link
    output logic debugScanClock,
    output logic scanShift,
    output logic scanDataIn,
    output logic scanUpdate,
    output logic resumeSelected,
    output logic tapRunTestIdle
);
    // Kept running so the link side can follow the halted state
    initial begin
        debugScanClock = 1'b0;
        scanShift = 1'b0;
        scanDataIn = 1'b0;
        scanUpdate = 1'b0;
        resumeSelected = 1'b0;
        tapRunTestIdle = 1'b0;
        #3;
        forever #6 debugScanClock = ~debugScanClock;
    end

    // Flag first, then instruction from bit 31 down
    task automatic scanWord(input logic flag, input logic [31:0] instr);
        logic [32:0] word;
        word = {flag, instr};
        for (int i = 32; i >= 0; i--) begin
            @(posedge debugScanClock);
            scanShift <= 1'b1;
            scanDataIn <= word[i];
        end
        @(posedge debugScanClock);
        scanShift <= 1'b0;
        scanDataIn <= ~word[0];
        scanUpdate <= 1'b1;
        @(posedge debugScanClock);
        scanUpdate <= 1'b0;
        repeat (4) @(posedge debugScanClock);
    endtask : scanWord

    // Idle entry held back so several cores could be primed first
    task automatic resume(input int hold);
        @(posedge debugScanClock);
        resumeSelected <= 1'b1;
        repeat (hold) @(posedge debugScanClock);
        tapRunTestIdle <= 1'b1;
        repeat (3) @(posedge debugScanClock);
        tapRunTestIdle <= 1'b0;
        resumeSelected <= 1'b0;
        repeat (8) @(posedge debugScanClock);
    endtask : resume
endmodule : dxr_debugger_model

// file: tb_top.sv
// Self-checking bench for debug entry, exit and resynchronisation
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin badCount++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
    // System side
    logic                          clock;
    logic                          rst;
    dxr_pkg::dxr_core_in_type      coreIn;
    dxr_pkg::dxr_core_in_type      ev;
    logic                          debugAcknowledge;
    logic                          debugClockSelect;
    logic                          fetchEnable;
    logic                          pipelineFlush;
    dxr_pkg::dxr_status_type       dbgStatus;
    // Scan side
    logic                          debugScanClock;
    logic                          scanShift;
    logic                          scanDataIn;
    logic                          scanUpdate;
    logic                          resumeSelected;
    logic                          tapRunTestIdle;
    logic                          chainSystemMode;
    logic                          systemSpeedFlag;
    logic [dxr_pkg::INSTR_W-1:0]   loadedInstr;
    logic [31:0]                   br;
    int                            badCount;
    int                            comparisons;
    logic [1:0]                    exitFetchCnt;
    logic                          trimmedAck;

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    dxr_debug_exit_resync u_dxr_debug_exit_resync (
        .clock(clock), .rst(rst), .coreIn(coreIn),
        .debugAcknowledge(debugAcknowledge), .debugClockSelect(debugClockSelect),
        .fetchEnable(fetchEnable), .pipelineFlush(pipelineFlush), .dbgStatus(dbgStatus),
        .debugScanClock(debugScanClock), .scanShift(scanShift), .scanDataIn(scanDataIn),
        .scanUpdate(scanUpdate), .resumeSelected(resumeSelected), .tapRunTestIdle(tapRunTestIdle),
        .chainSystemMode(chainSystemMode), .systemSpeedFlag(systemSpeedFlag), .loadedInstr(loadedInstr)
    );

    dxr_debugger_model u_dxr_debugger_model (
        .debugScanClock(debugScanClock), .scanShift(scanShift), .scanDataIn(scanDataIn),
        .scanUpdate(scanUpdate), .resumeSelected(resumeSelected), .tapRunTestIdle(tapRunTestIdle)
    );

    // Fetch mask beside the core: exact three-fetch cut, since the core's own may linger
    always_ff @(posedge clock) begin
        if (rst || !debugAcknowledge) begin
            exitFetchCnt <= 2'h0;
        end else if (fetchEnable && coreIn.instrFetch && exitFetchCnt != 2'h3) begin
            exitFetchCnt <= exitFetchCnt + 2'h1;
        end
    end

    assign trimmedAck = debugAcknowledge && (exitFetchCnt != 2'h3);

    task automatic tallyAndFinish();
        $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tallyAndFinish

    // Bounded wait: 0 ack, 1 clock select, else fetch enable
    task automatic waitSig(input int sel, input logic val);
        logic now;
        for (int i = 0; i < 200; i++) begin
            @(posedge clock);
            #1;
            case (sel)
                0: now = debugAcknowledge;
                1: now = debugClockSelect;
                default: now = fetchEnable;
            endcase
            if (now === val) return;
        end
        badCount++;
        tallyAndFinish();
    endtask : waitSig

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    // Four cycles; the scan side still applies it on its third edge
    task automatic doReset();
        @(posedge clock);
        rst <= 1'b1;
        coreIn <= '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        settle(6);
    endtask : doReset

    task automatic enter(input dxr_pkg::dxr_core_in_type cause, input logic [17:0] bytes);
        @(posedge clock);
        coreIn <= cause;
        waitSig(0, 1'b1);
        `CHECK(pipelineFlush, 1'b1)
        `CHECK(fetchEnable, 1'b0)
        `CHECK(dbgStatus.pcOffset, 16'h0004)
        `CHECK(dbgStatus.pcOffsetBytes, bytes)
        @(posedge clock);
        coreIn <= '0;
        #1;
        `CHECK(debugClockSelect, 1'b1)
        `CHECK(pipelineFlush, 1'b0)
        `CHECK(debugAcknowledge, 1'b1)
    endtask : enter

    task automatic fetchOnce();
        @(posedge clock);
        coreIn.instrFetch <= 1'b1;
        @(posedge clock);
        coreIn.instrFetch <= 1'b0;
    endtask : fetchOnce

    task automatic testEntryKinds();
        doReset();
        `CHECK({debugAcknowledge, debugClockSelect, fetchEnable, chainSystemMode}, 4'h2)
        `CHECK(dbgStatus.pcOffset, 16'h0000)
        ev = '0;
        ev.watchpointHit = 1'b1;
        ev.dataAbort = 1'b1;
        @(posedge clock);
        coreIn <= ev;
        settle(8);
        `CHECK(debugAcknowledge, 1'b0)
        ev.abortVectorFetch = 1'b1;
        enter(ev, 18'h00010);
        `CHECK(dbgStatus.abortMode, 1'b1)
        doReset();
        ev = '0;
        ev.watchpointHit = 1'b1;
        ev.exceptionPending = 1'b1;
        enter(ev, 18'h00010);
        `CHECK(dbgStatus.exceptionMode, 1'b1)
        doReset();
        ev = '0;
        ev.debugRequest = 1'b1;
        ev.compressedState = 1'b1;
        enter(ev, 18'h00008);
        `CHECK(dbgStatus.compressedAtEntry, 1'b1)
    endtask : testEntryKinds

    task automatic testExitFlow();
        doReset();
        ev = '0;
        ev.breakpointHit = 1'b1;
        ev.watchpointHit = 1'b1;
        enter(ev, 18'h00010);
        `CHECK({dbgStatus.abortMode, dbgStatus.exceptionMode}, 2'b00)
        u_dxr_debugger_model.scanWord(1'b0, 32'he1a01000);
        settle(4);
        `CHECK(systemSpeedFlag, 1'b0)
        `CHECK(loadedInstr, 32'he1a01000)
        `CHECK(dbgStatus.pcOffset, 16'h0005)
        // System-speed load, which aborts
        u_dxr_debugger_model.scanWord(1'b1, 32'he5901000);
        `CHECK(systemSpeedFlag, 1'b1)
        u_dxr_debugger_model.resume(1);
        waitSig(1, 1'b0);
        `CHECK(debugAcknowledge, 1'b1)
        ev = '0;
        ev.accessDone = 1'b1;
        ev.accessAbort = 1'b1;
        @(posedge clock);
        coreIn <= ev;
        @(posedge clock);
        coreIn <= '0;
        waitSig(0, 1'b0);
        settle(1);
        `CHECK(debugAcknowledge, 1'b1)
        `CHECK(dbgStatus.pcOffset, 16'h000a)
        `CHECK(dbgStatus.abortMode, 1'b1)
        waitSig(1, 1'b1);
        // Return branch, one more address for the branch itself
        br = 32'hea000000 | (32'h00ffffff & -32'd11);
        u_dxr_debugger_model.scanWord(1'b0, br);
        settle(4);
        `CHECK(loadedInstr, br)
        `CHECK(dbgStatus.pcOffset, 16'h000b)
        u_dxr_debugger_model.scanWord(1'b1, dxr_pkg::NOP_WORD);
        settle(10);
        `CHECK({debugClockSelect, fetchEnable}, 2'b10)
        u_dxr_debugger_model.resume(6);
        waitSig(2, 1'b1);
        `CHECK(chainSystemMode, 1'b1)
        `CHECK(debugClockSelect, 1'b0)
        `CHECK(debugAcknowledge, 1'b1)
        fetchOnce();
        fetchOnce();
        settle(4);
        `CHECK(debugAcknowledge, 1'b1)
        `CHECK(trimmedAck, 1'b1)
        fetchOnce();
        settle(1);
        `CHECK(debugAcknowledge, 1'b1)
        `CHECK(trimmedAck, 1'b0)
        settle(2);
        `CHECK(debugAcknowledge, 1'b0)
        `CHECK(fetchEnable, 1'b1)
    endtask : testExitFlow

    initial begin
        rst = 1'b1;
        coreIn = '0;
        ev = '0;
        br = '0;
        badCount = 0;
        comparisons = 0;
        testEntryKinds();
        testExitFlow();
        tallyAndFinish();
    end
endmodule : tb_top
